// [logic/triple_timer_map.svh]
// Purpose: constants of the triple event timer
// Assumes: 100 MHz ref_clk
// Notes: widths and reset values
`ifndef TRIPLE_TIMER_MAP_SVH
`define TRIPLE_TIMER_MAP_SVH
`define TT_CHANNELS 3
`define TT_COUNT_W 24
`define TT_COUNT_RST 24'h000000
`define TT_PULSE_LEN 8'h01
`endif

// [logic/triple_timer_pkg.sv]
// Purpose: types of the triple event timer
// Assumes: triple_timer_map.svh constants
// Notes: modes and per-channel carriers
`include "triple_timer_map.svh"
package triple_timer_pkg;
   // channel operating mode
   typedef enum logic [2:0] {
      mode_gpio,
      mode_timer_out,
      mode_event_count,
      mode_pulse_width,
      mode_period
   } mode_type;

   // software configuration of one channel
   typedef struct packed {
      logic enable;
      mode_type mode;
      logic ext_clock;
      logic ext_rising;
      logic [`TT_COUNT_W-1:0] compare;
   } chan_cfg_type;

   // general-purpose use of the pin
   typedef struct packed {
      logic dir_out;
      logic out_level;
   } gpio_ctl_type;

   // results shown to software
   typedef struct packed {
      logic [`TT_COUNT_W-1:0] count;
      logic [`TT_COUNT_W-1:0] capture;
      logic capture_valid;
      logic gpio_in;
   } chan_stat_type;
endpackage : triple_timer_pkg

// [logic/timer_channel.sv]
// Purpose: one independent timer channel with its pin
// Assumes: pin input already outside the clock domain
// Notes: pin oe is low while driving
`timescale 1ns/1ps
`include "triple_timer_map.svh"
module timer_channel
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   // software side
   input triple_timer_pkg::chan_cfg_type cfg,
   input triple_timer_pkg::gpio_ctl_type gpio,
   output triple_timer_pkg::chan_stat_type stat,
   output logic irq,
   // pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [`TT_COUNT_W-1:0] count;
      logic [`TT_COUNT_W-1:0] capture;
      logic cap_valid;
      logic measuring;
      logic irq;
      logic pulse;
   } state_type;

   state_type st_q;
   state_type st_d;
   logic edge_r;
   logic edge_f;
   logic tick;
   logic in_mode;
   logic hit;

   // edges from the synchronised value, never the first stage
   assign edge_r = st_q.s2 & ~st_q.s3;
   assign edge_f = ~st_q.s2 & st_q.s3;
   assign in_mode = cfg.mode inside {triple_timer_pkg::mode_event_count,
      triple_timer_pkg::mode_pulse_width, triple_timer_pkg::mode_period};
   // clock source chosen per channel
   assign tick = cfg.ext_clock ? (cfg.ext_rising ? edge_r : edge_f) : 1'b1;
   assign hit = (st_q.count == cfg.compare);

   // next state
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.irq = 1'b0;
      st_d.pulse = 1'b0;
      if (!cfg.enable)
      begin
         st_d.count = `TT_COUNT_RST;
         st_d.measuring = 1'b0;
      end
      else
      begin
         unique case (cfg.mode)
            triple_timer_pkg::mode_timer_out, triple_timer_pkg::mode_event_count:
            begin
               if ((cfg.mode == triple_timer_pkg::mode_event_count) ? (edge_r | edge_f) & tick : tick)
               begin
                  if (hit)
                  begin
                     st_d.count = `TT_COUNT_RST;
                     st_d.irq = 1'b1;
                     st_d.pulse = 1'b1;
                  end
                  else
                     st_d.count = st_q.count + 1'b1;
               end
            end
            triple_timer_pkg::mode_pulse_width:
            begin
               // high time between a rising and the next falling edge
               if (edge_r)
               begin
                  st_d.count = `TT_COUNT_RST;
                  st_d.measuring = 1'b1;
               end
               else if (edge_f && st_q.measuring)
               begin
                  st_d.capture = st_q.count;
                  st_d.cap_valid = 1'b1;
                  st_d.irq = 1'b1;
                  st_d.measuring = 1'b0;
               end
               else if (st_q.measuring)
                  st_d.count = st_q.count + 1'b1;
            end
            triple_timer_pkg::mode_period:
            begin
               // rising to rising; the first edge only arms the count
               if (edge_r)
               begin
                  if (st_q.measuring)
                  begin
                     st_d.capture = st_q.count + 1'b1;
                     st_d.cap_valid = 1'b1;
                     st_d.irq = 1'b1;
                  end
                  st_d.count = `TT_COUNT_RST;
                  st_d.measuring = 1'b1;
               end
               else if (st_q.measuring)
                  st_d.count = st_q.count + 1'b1;
            end
            default:
               st_d.count = `TT_COUNT_RST;
         endcase
      end
   end

   // state register, frozen by the clock enable
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         st_q <= '0;
      else if (clk_en)
         st_q <= st_d;
   end

   // pin mux: timer output, input in measuring modes, else gpio; srst does not touch it, cfg and gpio decide oe_n
   always_comb
   begin
      if (cfg.enable && cfg.mode == triple_timer_pkg::mode_timer_out)
      begin
         pin_oe_n = 1'b0;
         pin_out = st_q.pulse;
      end
      else if ((!cfg.enable || !in_mode) && gpio.dir_out)
      begin
         pin_oe_n = 1'b0;
         pin_out = gpio.out_level;
      end
      else
      begin
         pin_oe_n = 1'b1;
         pin_out = 1'b0;
      end
   end

   assign irq = st_q.irq;
   assign stat.count = st_q.count;
   assign stat.capture = st_q.capture;
   assign stat.capture_valid = st_q.cap_valid;
   assign stat.gpio_in = st_q.s2;

   // pulse follows a compare hit by one cycle
   hit_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
      clk_en && cfg.enable && cfg.mode == triple_timer_pkg::mode_timer_out && !cfg.ext_clock && hit
      |=> st_q.pulse && irq)
      else $error("timer pulse missing after compare");
   // pin mux is combinational from cfg, so it is checked in the same cycle
   pin_mux_a: assert property (@(posedge ref_clk) disable iff (srst)
      cfg.enable && cfg.mode == triple_timer_pkg::mode_timer_out |-> !pin_oe_n && pin_out == st_q.pulse)
      else $error("timer pulse not on pin");
   irq_cause_a: assert property (@(posedge ref_clk) disable iff (srst)
      irq |-> $past(cfg.enable))
      else $error("interrupt from disabled channel");
   gpio_release_a: assert property (@(posedge ref_clk) disable iff (srst)
      !cfg.enable && !gpio.dir_out |-> pin_oe_n)
      else $error("disabled channel drives pin");
   edge_sync_a: assert property (@(posedge ref_clk) disable iff (srst)
      clk_en [*3] |=> (edge_r == ($past(pin_in, 2) && !$past(pin_in, 3))))
      else $error("pin edge not synchronised");
endmodule : timer_channel

// [logic/triple_event_timer.sv]
// Purpose: top of the triple event timer
// Assumes: configuration arrives from same-clock logic
// Notes: pin inputs are two-stage synchronised inside each channel
`timescale 1ns/1ps
`include "triple_timer_map.svh"
module triple_event_timer
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   // configuration and status per channel
   input triple_timer_pkg::chan_cfg_type [`TT_CHANNELS-1:0] cfg,
   input triple_timer_pkg::gpio_ctl_type [`TT_CHANNELS-1:0] gpio,
   output triple_timer_pkg::chan_stat_type [`TT_CHANNELS-1:0] stat,
   output logic [`TT_CHANNELS-1:0] irq,
   // timer pins
   input wire logic timer_pin_zero_in,
   output logic timer_pin_zero_out,
   output logic timer_pin_zero_oe_n,
   input wire logic timer_pin_one_in,
   output logic timer_pin_one_out,
   output logic timer_pin_one_oe_n,
   input wire logic timer_pin_two_in,
   output logic timer_pin_two_out,
   output logic timer_pin_two_oe_n
);
   logic [`TT_CHANNELS-1:0] pin_in;
   logic [`TT_CHANNELS-1:0] pin_out;
   logic [`TT_CHANNELS-1:0] pin_oe_n;

   assign pin_in = {timer_pin_two_in, timer_pin_one_in, timer_pin_zero_in};
   assign {timer_pin_two_out, timer_pin_one_out, timer_pin_zero_out} = pin_out;
   assign {timer_pin_two_oe_n, timer_pin_one_oe_n, timer_pin_zero_oe_n} = pin_oe_n;

   // one channel each; no shared state so they stay independent
   for (genvar i = 0; i < `TT_CHANNELS; i++)
   begin : g_chan
      timer_channel u_chan
      (
         .ref_clk(ref_clk),
         .srst(srst),
         .clk_en(clk_en),
         .cfg(cfg[i]),
         .gpio(gpio[i]),
         .stat(stat[i]),
         .irq(irq[i]),
         .pin_in(pin_in[i]),
         .pin_out(pin_out[i]),
         .pin_oe_n(pin_oe_n[i])
      );
   end

   // pin zero is an input the cycle after reset while channel 0 is disabled and not a gpio output
   reset_input_a: assert property (@(posedge ref_clk)
      srst && !cfg[0].enable && !gpio[0].dir_out |=> timer_pin_zero_oe_n)
      else $error("pin driven after reset");
endmodule : triple_event_timer

// [testbench/pin_source.sv]
// Purpose: outside source on one timer pin
// Assumes: tb holds each level two cycles or more
// Notes: device drive wins while its oe_n is low
`timescale 1ns/1ps
module pin_source
(
   // levels
   input wire logic drive_lvl,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   // wire
   output logic pin
);
   // ==========
   // resolution: no pull, so the source always drives when released
   assign pin = dev_oe_n ? drive_lvl : dev_out;
endmodule : pin_source

// [testbench/tb.sv]
// Purpose: self-checking bench of the triple event timer
// Assumes: inputs move at the falling edge
// Notes: clk_en high except in the freeze check
`timescale 1ns/1ps
`include "triple_timer_map.svh"
module tb;
   logic ref_clk, srst;
   triple_timer_pkg::chan_cfg_type [`TT_CHANNELS-1:0] cfg;
   triple_timer_pkg::gpio_ctl_type [`TT_CHANNELS-1:0] gpio;
   triple_timer_pkg::chan_stat_type [`TT_CHANNELS-1:0] stat;
   logic clk_en;
   logic [2:0] irq, lvl;
   wire [2:0] pin, out, oe_n;
   int fail_count = 0, checked = 0, cycles = 0;
   // ==========
   // design and pin sources
   triple_event_timer dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .cfg(cfg), .gpio(gpio),
      .stat(stat), .irq(irq), .timer_pin_zero_in(pin[0]), .timer_pin_zero_out(out[0]),
      .timer_pin_zero_oe_n(oe_n[0]), .timer_pin_one_in(pin[1]), .timer_pin_one_out(out[1]),
      .timer_pin_one_oe_n(oe_n[1]), .timer_pin_two_in(pin[2]), .timer_pin_two_out(out[2]),
      .timer_pin_two_oe_n(oe_n[2]));
   pin_source src0 (.drive_lvl(lvl[0]), .dev_out(out[0]), .dev_oe_n(oe_n[0]), .pin(pin[0]));
   pin_source src1 (.drive_lvl(lvl[1]), .dev_out(out[1]), .dev_oe_n(oe_n[1]), .pin(pin[1]));
   pin_source src2 (.drive_lvl(lvl[2]), .dev_out(out[2]), .dev_oe_n(oe_n[2]), .pin(pin[2]));
   // ==========
   // shared helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // drive one pin level and hold it, never below two cycles
   task automatic hold(input int ch, input logic v, input int n);
      lvl[ch] = v;
      cyc(n);
   endtask : hold
   task automatic final_report;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   // ==========
   // scenarios
   task automatic t_reset;
      chk(oe_n, 3'h7);
      lvl = 3'h5;
      cyc(4);
      chk({stat[2].gpio_in, stat[1].gpio_in, stat[0].gpio_in}, 3'h5);
   endtask : t_reset
   task automatic t_gpio;
      gpio[1] = '{dir_out: 1'b1, out_level: 1'b1};
      cyc(1);
      chk({oe_n[1], pin[1]}, 2'h1);
      gpio[1].out_level = 1'b0;
      cyc(1);
      chk(pin[1], 1'b0);
      gpio[1] = '0;
      cyc(1);
      chk(oe_n[1], 1'b1);
   endtask : t_gpio
   // three timers at different periods must each keep their own spacing
   task automatic t_timer;
      int last[3], hits[3];
      for (int i = 0; i < 3; i++)
      begin
         cfg[i] = '0;
         cfg[i].enable = 1'b1;
         cfg[i].mode = triple_timer_pkg::mode_timer_out;
         cfg[i].compare = 24'(i + 2);
         last[i] = -1;
         hits[i] = 0;
      end
      for (int n = 0; n < 40; n++)
      begin
         cyc(1);
         for (int i = 0; i < 3; i++)
            if (irq[i] === 1'b1)
            begin
               if (last[i] >= 0)
                  chk(24'(n - last[i]), 24'(i + 3));
               chk({oe_n[i], pin[i]}, 2'h1);
               last[i] = n;
               hits[i]++;
            end
      end
      for (int i = 0; i < 3; i++)
         chk(24'(hits[i] > 3), 24'h000001);
      cfg = '0;
      cyc(2);
   endtask : t_timer
   task automatic t_event;
      // settle the pin first so the edge detector holds no stale edge
      hold(2, 1'b0, 4);
      cfg[2] = '0;
      cfg[2].enable = 1'b1;
      cfg[2].mode = triple_timer_pkg::mode_event_count;
      cfg[2].ext_clock = 1'b1;
      cfg[2].ext_rising = 1'b1;
      cfg[2].compare = 24'h0000ff;
      hold(2, 1'b0, 4);
      for (int k = 0; k < 5; k++)
      begin
         hold(2, 1'b1, 3);
         hold(2, 1'b0, 3);
      end
      cyc(4);
      chk(stat[2].count, 24'h000005);
      // with the clock enable low the whole channel, synchroniser too, is frozen
      clk_en = 1'b0;
      hold(2, 1'b1, 3);
      hold(2, 1'b0, 3);
      clk_en = 1'b1;
      cyc(4);
      chk(stat[2].count, 24'h000005);
      cfg = '0;
      cyc(2);
   endtask : t_event
   task automatic t_measure;
      cfg[0] = '0;
      cfg[0].enable = 1'b1;
      cfg[0].mode = triple_timer_pkg::mode_pulse_width;
      cfg[1] = cfg[0];
      cfg[1].mode = triple_timer_pkg::mode_period;
      lvl = 3'h0;
      cyc(4);
      hold(0, 1'b1, 6);
      hold(0, 1'b0, 4);
      for (int k = 0; k < 3; k++)
      begin
         hold(1, 1'b1, 3);
         hold(1, 1'b0, 7);
      end
      cyc(4);
      chk({stat[0].capture_valid, stat[0].capture}, 25'h1000005);
      chk({stat[1].capture_valid, stat[1].capture}, 25'h100000a);
      cfg = '0;
   endtask : t_measure
   // ==========
   // clock, guard and main sequence
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         final_report();
      end
   end
   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      cfg = '0;
      gpio = '0;
      lvl = 3'h0;
      cyc(10);
      srst = 1'b0;
      cyc(1);
      t_reset();
      t_gpio();
      t_timer();
      t_event();
      t_measure();
      final_report();
   end
endmodule : tb
